// [rtl/cmd_pkg.sv]
// Shared constants and types for the serial command handler
package cmd_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 100;
  localparam int NV_WRITE_TIME_US = 100000;
  localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_US * CLK_FREQ_MHZ;
  localparam int HOLD_W = 24;

  // ---------------------------------------------------------------
  // Framing and buffering
  // ---------------------------------------------------------------
  localparam int DATA_BITS = 8;
  localparam int LINE_MAX = 16;
  localparam int LEN_W = 5;
  localparam int POS_DEST = 1;
  localparam int POS_CODE = 5;
  localparam int MIN_LEN = 7;
  localparam int FIFO_DEPTH = 16;
  localparam int REPLY_W = 9;

  // ---------------------------------------------------------------
  // Characters, addresses and command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_EQ = 8'h3D;
  localparam logic [15:0] DEST_GLOBAL = 16'h3939;
  localparam logic [15:0] DEST_HOST = 16'h3030;
  localparam logic [15:0] CODE_NV_UNLOCK = 16'h4557;
  localparam logic [15:0] CODE_P_HOLD = 16'h5035;
  localparam logic [15:0] CODE_P_PER_HOLD = 16'h5036;
  localparam logic [15:0] CODE_T_HOLD = 16'h5135;
  localparam logic [15:0] CODE_T_PER_HOLD = 16'h5136;
  localparam logic [15:0] CODE_P_PER_CONT = 16'h5032;
  localparam logic [15:0] CODE_P_CONT = 16'h5034;
  localparam logic [15:0] CODE_P_BURST = 16'h5037;
  localparam logic [15:0] CODE_T_PER_CONT = 16'h5132;
  localparam logic [15:0] CODE_T_CONT = 16'h5134;

  typedef logic [LINE_MAX-1:0][7:0] line_t;

endpackage : cmd_pkg

// [rtl/byte_link.sv]
// Byte stream between the command core and the serial port
`timescale 1ns/10ps
interface byte_link;
  logic txValid;
  logic txReady;
  logic [7:0] txData;
  logic rxValid;
  logic [7:0] rxData;
  modport core (output txValid, txData, input txReady, rxValid, rxData);
  modport phy (input txValid, txData, output txReady, rxValid, rxData);
endinterface : byte_link

// [rtl/reply_fifo.sv]
// Reply character FIFO with valid/ready on both sides
`timescale 1ns/10ps
module reply_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic flush,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  // Pointers wrap naturally, so DEPTH must be a power of two
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } fifo_s;

  fifo_s s, n;
  logic push, pop;

  assign inReady = s.count != (AW+1)'(DEPTH);
  assign outValid = s.count != '0;
  assign outData = s.mem[s.rd];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    n = s;
    if (push) begin
      n.mem[s.wr] = inData;
      n.wr = s.wr + 1'b1;
    end
    if (pop) begin
      n.rd = s.rd + 1'b1;
    end
    n.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      n.wr = '0;
      n.rd = '0;
      n.count = '0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  chk_fifo_bound: assert property (@(posedge mclk) disable iff (!nrst)
    s.count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule : reply_fifo

// [rtl/serial_port.sv]
// Asynchronous serial transmitter and receiver, 8N1
`timescale 1ns/10ps
module serial_port (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Bit period in clock cycles
  input wire logic [15:0] baudDiv,
  // Line pins
  input wire logic rxPin,
  output logic txPin,
  // Byte stream
  byte_link.phy lnk
);
  import cmd_pkg::*;

  typedef enum logic [1:0] {B_IDLE, B_START, B_DATA, B_STOP} bit_e;

  typedef struct packed {
    logic rxMeta;
    logic rxSync;
    bit_e rxSt;
    logic [15:0] rxCnt;
    logic [3:0] rxBit;
    logic [7:0] rxShift;
    logic rxValid;
    bit_e txSt;
    logic [15:0] txCnt;
    logic [3:0] txBit;
    logic [7:0] txShift;
    logic txLine;
  } port_s;

  port_s s, n;

  assign txPin = s.txLine;
  assign lnk.txReady = s.txSt == B_IDLE;
  assign lnk.rxValid = s.rxValid;
  assign lnk.rxData = s.rxShift;

  // ---------------------------------------------------------------
  // Receive: sample mid-bit, stop bit must be high
  // ---------------------------------------------------------------
  always_comb begin
    n = s;
    n.rxValid = 1'b0;
    n.rxMeta = rxPin;
    n.rxSync = s.rxMeta;
    unique case (s.rxSt)
      B_IDLE: if (!s.rxSync) begin
        n.rxSt = B_START;
        n.rxCnt = baudDiv >> 1;
      end
      B_START: if (s.rxCnt == '0) begin
        n.rxSt = s.rxSync ? B_IDLE : B_DATA;
        n.rxCnt = baudDiv - 16'h0001;
        n.rxBit = '0;
      end else begin
        n.rxCnt = s.rxCnt - 16'h0001;
      end
      B_DATA: if (s.rxCnt == '0) begin
        n.rxShift = {s.rxSync, s.rxShift[7:1]};
        n.rxCnt = baudDiv - 16'h0001;
        n.rxBit = s.rxBit + 1'b1;
        if (s.rxBit == 4'(DATA_BITS - 1)) n.rxSt = B_STOP;
      end else begin
        n.rxCnt = s.rxCnt - 16'h0001;
      end
      B_STOP: if (s.rxCnt == '0) begin
        // Framing errors are dropped, not passed on
        n.rxSt = B_IDLE;
        n.rxValid = s.rxSync;
      end else begin
        n.rxCnt = s.rxCnt - 16'h0001;
      end
    endcase

    // -------------------------------------------------------------
    // Transmit: start, eight data bits, one stop bit, no parity
    // -------------------------------------------------------------
    unique case (s.txSt)
      B_IDLE: if (lnk.txValid) begin
        n.txShift = lnk.txData;
        n.txSt = B_START;
        n.txCnt = baudDiv - 16'h0001;
        n.txLine = 1'b0;
      end
      B_START: if (s.txCnt == '0) begin
        n.txSt = B_DATA;
        n.txLine = s.txShift[0];
        n.txCnt = baudDiv - 16'h0001;
        n.txBit = '0;
      end else begin
        n.txCnt = s.txCnt - 16'h0001;
      end
      B_DATA: if (s.txCnt == '0) begin
        n.txCnt = baudDiv - 16'h0001;
        n.txBit = s.txBit + 1'b1;
        n.txShift = s.txShift >> 1;
        n.txLine = s.txShift[1];
        if (s.txBit == 4'(DATA_BITS - 1)) begin
          n.txSt = B_STOP;
          n.txLine = 1'b1;
        end
      end else begin
        n.txCnt = s.txCnt - 16'h0001;
      end
      B_STOP: if (s.txCnt == '0) begin
        n.txSt = B_IDLE;
      end else begin
        n.txCnt = s.txCnt - 16'h0001;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.rxMeta <= 1'b1;
      s.rxSync <= 1'b1;
      s.txLine <= 1'b1;
    end else begin
      s <= n;
    end
  end

  chk_start_low: assert property (@(posedge mclk) disable iff (!nrst)
    (s.txSt == B_IDLE && lnk.txValid) |=> !txPin)
    else $error("start bit not low");
  chk_stop_high: assert property (@(posedge mclk) disable iff (!nrst)
    (s.txSt == B_STOP) |-> txPin) else $error("stop bit not high");

endmodule : serial_port

// [rtl/serial_cmd_handler.sv]
// Daisy-chain serial command handler: framing, relay, replies, holdoff
`timescale 1ns/10ps

// What this block does
// - Characters are 8 data bits, no parity, one stop bit, both lines.
// - Only transmit and receive data pins; no modem handshake outputs.
// - Global command is forwarded down the loop before it executes.
// - Host sees a global command echoed, then its normal reply.
// - Unknown code addressed here is launched and aborts like any other; any reply comes from the executor.
// - Sample-and-hold commands store a value and send no reply.
// - Other valid commands reply, possibly seconds later.
// - Every reply frame starts with an asterisk.
// - A new command aborts any operation, including continuous output.
// - Continuous sending runs until another command stops it.
// - Power-up send mode may start continuous output without command.
// - During a nonvolatile write, own commands ignored; reply after.
// - During a nonvolatile write, traffic for others still relayed.
// - Reading a stored parameter causes no write holdoff.
// - Nonvolatile write needs an unlock command covering one string.
module serial_cmd_handler #(
  parameter int unsigned HOLD_CYCLES = cmd_pkg::NV_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Serial pins
  input wire logic rxPin,
  output logic txPin,
  // Configuration
  input wire logic [15:0] unitId,
  input wire logic [15:0] baudDiv,
  input wire logic powerUpSendMode,
  // Command towards the executor
  output logic cmdValid,
  output logic [15:0] cmdCode,
  output logic cmdWrite,
  output logic cmdGlobal,
  output cmd_pkg::line_t cmdLine,
  output logic [cmd_pkg::LEN_W-1:0] cmdLen,
  output logic abortOp,
  output logic contActive,
  output logic nvWriteStart,
  output logic nvBusy,
  // Reply characters from the executor
  input wire logic replyValid,
  output logic replyReady,
  input wire logic [7:0] replyData,
  input wire logic replyLast
);
  import cmd_pkg::*;

  typedef enum logic [2:0] {
    T_IDLE, T_RELAY, T_STAR, T_HEAD, T_PAYLOAD, T_DRAIN
  } tx_e;

  typedef struct packed {
    tx_e tx;
    line_t lineBuf;
    logic [LEN_W-1:0] lineLen;
    logic collecting;
    line_t fwdBuf;
    logic [LEN_W-1:0] fwdLen;
    logic fwdPend;
    logic [LEN_W-1:0] txIdx;
    logic execPend;
    line_t cmdLine;
    logic [LEN_W-1:0] cmdLen;
    logic [15:0] cmdCode;
    logic cmdWrite;
    logic cmdGlobal;
    logic cmdValid;
    logic unlocked;
    logic [HOLD_W-1:0] holdCnt;
    logic nvWriteStart;
    logic abortOp;
    logic contActive;
    logic dropReply;
    logic started;
  } state_s;

  state_s s, n;
  logic doExec, relayDone, lineDone, selfHit, globHit;
  logic [15:0] dest;
  logic fifoValid, fifoReady;
  logic [REPLY_W-1:0] fifoData;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] pairAt(input line_t b, input int p);
    return {b[p], b[p+1]};
  endfunction : pairAt

  function automatic logic hasEquals(input line_t b,
                                     input logic [LEN_W-1:0] len);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < LINE_MAX; i++) begin
      if (LEN_W'(i) < len && b[i] == CH_EQ) hit = 1'b1;
    end
    return hit;
  endfunction : hasEquals

  function automatic logic isSampleHold(input logic [15:0] c);
    return c == CODE_P_HOLD || c == CODE_P_PER_HOLD ||
           c == CODE_T_HOLD || c == CODE_T_PER_HOLD;
  endfunction : isSampleHold

  function automatic logic isContinuous(input logic [15:0] c);
    return c == CODE_P_PER_CONT || c == CODE_P_CONT ||
           c == CODE_P_BURST || c == CODE_T_PER_CONT || c == CODE_T_CONT;
  endfunction : isContinuous

  // ---------------------------------------------------------------
  // Serial port and reply buffer
  // ---------------------------------------------------------------
  byte_link lnk ();

  // Only the two data lines exist; no handshake pins are driven
  serial_port u_port (
    .mclk(mclk),
    .nrst(nrst),
    .baudDiv(baudDiv),
    .rxPin(rxPin),
    .txPin(txPin),
    .lnk(lnk.phy)
  );

  reply_fifo #(.WIDTH(REPLY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .flush(s.abortOp),
    .inValid(replyValid),
    .inReady(replyReady),
    .inData({replyLast, replyData}),
    .outValid(fifoValid),
    .outReady(fifoReady),
    .outData(fifoData)
  );

  assign cmdValid = s.cmdValid;
  assign cmdCode = s.cmdCode;
  assign cmdWrite = s.cmdWrite;
  assign cmdGlobal = s.cmdGlobal;
  assign cmdLine = s.cmdLine;
  assign cmdLen = s.cmdLen;
  assign abortOp = s.abortOp;
  assign contActive = s.contActive;
  assign nvWriteStart = s.nvWriteStart;
  assign nvBusy = s.holdCnt != '0;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    n = s;
    n.cmdValid = 1'b0;
    n.abortOp = 1'b0;
    n.nvWriteStart = 1'b0;
    doExec = 1'b0;
    relayDone = 1'b0;
    lineDone = 1'b0;
    lnk.txValid = 1'b0;
    lnk.txData = 8'h00;
    fifoReady = 1'b0;
    if (s.holdCnt != '0) n.holdCnt = s.holdCnt - 1'b1;

    // Power-up mode is caught one cycle after reset release
    if (!s.started) begin
      n.started = 1'b1;
      n.contActive = powerUpSendMode;
    end

    // Transmit sequencer; relay has priority over replies
    unique case (s.tx)
      T_IDLE: begin
        if (s.fwdPend) begin
          n.tx = T_RELAY;
          n.txIdx = '0;
          n.fwdPend = 1'b0;
        end else if (fifoValid && s.holdCnt == '0 && !s.execPend &&
                     !s.abortOp) begin
          // Waiting on the executor may take seconds; no timeout
          n.tx = s.dropReply ? T_DRAIN : T_STAR;
        end
      end
      T_RELAY: begin
        lnk.txValid = 1'b1;
        lnk.txData = s.fwdBuf[s.txIdx[3:0]];
        if (lnk.txReady) begin
          n.txIdx = s.txIdx + 1'b1;
          if (s.txIdx == s.fwdLen - 1'b1) begin
            n.tx = T_IDLE;
            relayDone = 1'b1;
          end
        end
      end
      T_STAR: begin
        lnk.txValid = 1'b1;
        lnk.txData = CH_STAR;
        if (lnk.txReady) begin
          n.tx = T_HEAD;
          n.txIdx = '0;
        end
      end
      T_HEAD: begin
        lnk.txValid = 1'b1;
        unique case (s.txIdx[1:0])
          2'h0: lnk.txData = DEST_HOST[15:8];
          2'h1: lnk.txData = DEST_HOST[7:0];
          2'h2: lnk.txData = unitId[15:8];
          2'h3: lnk.txData = unitId[7:0];
        endcase
        if (lnk.txReady) begin
          n.txIdx = s.txIdx + 1'b1;
          if (s.txIdx[1:0] == 2'h3) n.tx = T_PAYLOAD;
        end
      end
      T_PAYLOAD: begin
        lnk.txValid = fifoValid;
        lnk.txData = fifoData[7:0];
        fifoReady = lnk.txReady;
        if (fifoValid && lnk.txReady && fifoData[8]) n.tx = T_IDLE;
      end
      T_DRAIN: begin
        fifoReady = 1'b1;
        if (fifoValid && fifoData[8]) n.tx = T_IDLE;
      end
      default: n.tx = T_IDLE;
    endcase

    // Global command runs only once its copy has left
    if (relayDone && s.execPend) begin
      n.execPend = 1'b0;
      doExec = s.holdCnt == '0;
    end

    // Line collector; an asterisk always restarts the line
    if (lnk.rxValid) begin
      if (lnk.rxData == CH_STAR) begin
        n.lineBuf[0] = CH_STAR;
        n.lineLen = LEN_W'(1);
        n.collecting = 1'b1;
      end else if (s.collecting) begin
        if (s.lineLen == LEN_W'(LINE_MAX)) begin
          // Overlong lines are dropped, never relayed
          n.collecting = 1'b0;
        end else begin
          n.lineBuf[s.lineLen[3:0]] = lnk.rxData;
          n.lineLen = s.lineLen + 1'b1;
          if (lnk.rxData == CH_CR) begin
            n.collecting = 1'b0;
            lineDone = 1'b1;
          end
        end
      end
    end

    dest = pairAt(n.lineBuf, POS_DEST);
    selfHit = dest == unitId;
    globHit = dest == DEST_GLOBAL;
    if (lineDone && n.lineLen > LEN_W'(MIN_LEN)) begin
      if (!selfHit) begin
        n.fwdBuf = n.lineBuf;
        n.fwdLen = n.lineLen;
        n.fwdPend = 1'b1;
      end
      if ((selfHit || globHit) && s.holdCnt == '0) begin
        n.cmdLine = n.lineBuf;
        n.cmdLen = n.lineLen;
        n.cmdCode = pairAt(n.lineBuf, POS_CODE);
        n.cmdWrite = hasEquals(n.lineBuf, n.lineLen);
        n.cmdGlobal = globHit;
        if (globHit) begin
          n.execPend = 1'b1;
          doExec = 1'b0;
        end else begin
          doExec = 1'b1;
        end
      end
    end

    // Launch: abort what runs, pick reply handling, gate writes
    if (doExec) begin
      n.cmdValid = 1'b1;
      n.abortOp = 1'b1;
      n.contActive = isContinuous(n.cmdCode);
      n.dropReply = isSampleHold(n.cmdCode);
      if (n.tx != T_RELAY) n.tx = T_IDLE;
      if (n.cmdWrite && s.unlocked) begin
        n.nvWriteStart = 1'b1;
        n.holdCnt = HOLD_W'(HOLD_CYCLES);
      end
      n.unlocked = n.cmdCode == CODE_NV_UNLOCK;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_reply_star: assert property (
    (s.tx == T_IDLE && n.tx == T_STAR) |=> lnk.txData == CH_STAR)
    else $error("reply does not open with star");
  chk_global_order: assert property (
    (s.cmdValid && s.cmdGlobal) |-> $past(s.tx) == T_RELAY)
    else $error("global command ran before relay");
  chk_hold_ignores: assert property (
    (s.holdCnt > HOLD_W'(1)) |=> !s.cmdValid)
    else $error("command taken during write");
  chk_hold_length: assert property (
    s.nvWriteStart |-> s.holdCnt == HOLD_W'(HOLD_CYCLES))
    else $error("write holdoff wrong length");
  chk_unlock_once: assert property (
    s.nvWriteStart |-> $past(s.unlocked) && !s.unlocked)
    else $error("write without unlock");
  chk_read_nohold: assert property (
    (s.cmdValid && !s.cmdWrite) |-> !s.nvWriteStart && !nvBusy)
    else $error("read caused holdoff");
  chk_abort_new: assert property (
    s.cmdValid |-> s.abortOp ##1 (!fifoValid &&
      (s.tx == T_IDLE || s.tx == T_RELAY)))
    else $error("new command did not abort");
  chk_cont_hold: assert property (
    (s.contActive && !doExec && s.started) |=> s.contActive)
    else $error("continuous output stopped on its own");
  chk_drop_quiet: assert property (
    s.dropReply |-> s.tx != T_STAR && s.tx != T_HEAD &&
      s.tx != T_PAYLOAD) else $error("dropped reply sent");
  chk_no_empty: assert property (
    (s.tx == T_IDLE && !fifoValid && !s.fwdPend) |=> s.tx == T_IDLE)
    else $error("frame begun without reply");
  chk_power_up: assert property (
    $rose(s.started) |-> s.contActive == $past(powerUpSendMode))
    else $error("power-up send mode ignored");

endmodule : serial_cmd_handler

// [dv/host_uart.sv]
// Host serial port model facing the command handler
`timescale 1ns/10ps
module host_uart #(
  parameter int DIV = 16
) (
  // Clock and line pins
  input wire logic mclk,
  input wire logic txPin,
  output logic rxPin
);
  byte got[$];
  initial rxPin = 1'b1;
  // ----
  // Send: start, 8 bits LSB first, one stop
  // ----
  task automatic send_line(input string s);
    logic [9:0] f;
    for (int i = 0; i < s.len(); i++) begin
      f = {1'b1, s[i], 1'b0};
      for (int b = 0; b < 10; b++) begin
        @(negedge mclk);
        rxPin = f[b];
        repeat (DIV - 1) @(negedge mclk);
      end
    end
  endtask : send_line
  // ----
  // Receive, sampled at bit centres
  // ----
  initial begin : rx
    logic [7:0] c;
    forever begin
      @(negedge txPin);
      repeat (DIV / 2) @(posedge mclk);
      for (int b = 0; b < 8; b++) begin
        repeat (DIV) @(posedge mclk);
        c[b] = txPin;
      end
      repeat (DIV) @(posedge mclk);
      // Power-up noise skipped until a star
      if (txPin === 1'b1 && (got.size() > 0 || c == 8'h2A))
        got.push_back(c);
    end
  end
endmodule : host_uart

// [dv/test_serial_cmd_handler.sv]
// Self-checking bench for the serial command handler
`timescale 1ns/10ps
module test_serial_cmd_handler;
  import cmd_pkg::*;
  localparam int DIV = 16;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic pwrMode = 1'b1;
  logic replyValid = 1'b0;
  logic replyLast = 1'b0;
  logic [7:0] replyData = 8'h00;
  logic txPin, rxPin, replyReady, cmdValid, cmdWrite, cmdGlobal;
  logic abortOp, contActive, nvWriteStart, nvBusy, lastGl, lastAb;
  logic [15:0] cmdCode, lastCode;
  line_t cmdLine;
  logic [LEN_W-1:0] cmdLen, lastLen;
  int n_fail = 0;
  int samples_checked = 0;
  int nCmd = 0;
  int nWr = 0;
  int cyc = 0;
  int seed = 60735;
  logic [7:0] d;
  byte expQ[$];
  always #5 mclk = ~mclk;

  serial_cmd_handler #(.HOLD_CYCLES(4000)) u_serial_cmd_handler (
    .mclk(mclk), .nrst(nrst), .rxPin(rxPin), .txPin(txPin),
    .unitId(16'h3031), .baudDiv(16'(DIV)),
    .powerUpSendMode(pwrMode), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdWrite(cmdWrite), .cmdGlobal(cmdGlobal), .cmdLine(cmdLine),
    .cmdLen(cmdLen), .abortOp(abortOp), .contActive(contActive),
    .nvWriteStart(nvWriteStart), .nvBusy(nvBusy),
    .replyValid(replyValid), .replyReady(replyReady),
    .replyData(replyData), .replyLast(replyLast));
  host_uart #(.DIV(DIV)) u_host_uart (
    .mclk(mclk), .txPin(txPin), .rxPin(rxPin));

  // ----
  // Launch monitor and hang guard
  // ----
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cmdValid === 1'b1) begin
      nCmd <= nCmd + 1;
      lastGl <= cmdGlobal;
      lastAb <= abortOp;
      lastCode <= cmdCode;
      lastLen <= cmdLen;
    end
    if (nvWriteStart === 1'b1) nWr <= nWr + 1;
    if (cyc == 60000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic cmp_val(input string n, input logic [15:0] e,
                         input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_val
  task automatic cmp_cnt(input string n, input int e, input int g);
    samples_checked++;
    if (g != e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
    end
  endtask : cmp_cnt
  task automatic push(input logic [7:0] v, input logic l);
    @(negedge mclk);
    replyValid = 1'b1;
    replyData = v;
    replyLast = l;
    while (replyReady !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    replyValid = 1'b0;
  endtask : push
  task automatic run(input string s, input int launch, input string rep);
    int n0;
    n0 = nCmd;
    u_host_uart.send_line(s);
    for (int i = 0; i < 2000 && nCmd == n0 && launch > 0; i++)
      @(posedge mclk);
    repeat (3) @(negedge mclk);
    cmp_cnt("launch", n0 + launch, nCmd);
    for (int i = 0; i < rep.len(); i++)
      push(rep[i], i == rep.len() - 1);
  endtask : run
  task automatic expect_s(input string s);
    for (int i = 0; i < s.len(); i++) expQ.push_back(s[i]);
  endtask : expect_s
  // Extra quiet time catches a stray trailing char
  task automatic check_tx();
    for (int i = 0; i < 20000 && u_host_uart.got.size() < expQ.size();
         i++) @(posedge mclk);
    repeat (12 * DIV) @(posedge mclk);
    cmp_cnt("txCount", expQ.size(), u_host_uart.got.size());
    foreach (expQ[i])
      if (i < u_host_uart.got.size())
        cmp_val("txChar", {8'h00, expQ[i]}, {8'h00, u_host_uart.got[i]});
    expQ.delete();
    u_host_uart.got.delete();
  endtask : check_tx
  task automatic end_of_test();
    $display("Checks %0d, failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // ----
  // Scenarios
  // ----
  initial begin
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    repeat (3) @(negedge mclk);
    cmp_val("contActive", 1, contActive);
    run("*0200P1\r", 0, "");
    expect_s("*0200P1\r");
    check_tx();
    run("*9900P1\r", 1, "12");
    cmp_val("global", 1, lastGl);
    cmp_val("code", 16'h5031, lastCode);
    cmp_val("len", 8, lastLen);
    cmp_val("lineTail", 16'h310D, {cmdLine[6], cmdLine[7]});
    cmp_val("abort", 1, lastAb);
    cmp_val("contActive", 0, contActive);
    expect_s("*9900P1\r*000112");
    check_tx();
    run("*0100P4\r", 1, "");
    cmp_val("contActive", 1, contActive);
    run("*0100ZQ\r", 1, "");
    cmp_val("contActive", 0, contActive);
    run("*0100P5\r", 1, "77");
    check_tx();
    run("*0100PR\r", 1, "5");
    cmp_val("nvBusy", 0, nvBusy);
    expect_s("*00015");
    check_tx();
    run("*0100PR=5\r", 1, "5");
    cmp_val("write", 1, cmdWrite);
    cmp_cnt("nvWrites", 0, nWr);
    expect_s("*00015");
    check_tx();
    run("*0100EW\r", 1, "");
    run("*0100PR=6\r", 1, "");
    cmp_cnt("nvWrites", 1, nWr);
    cmp_val("nvBusy", 1, nvBusy);
    expect_s("*0200VR\r*0001");
    // Holdoff keeps the FIFO from draining, so it fills
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      d = 8'($random(seed));
      expQ.push_back(d);
      push(d, i == FIFO_DEPTH - 1);
    end
    cmp_val("replyReady", 0, replyReady);
    run("*0100VR\r", 0, "");
    run("*0200VR\r", 0, "");
    check_tx();
    // Second reset, power-up sending off this time
    @(negedge mclk);
    nrst = 1'b0;
    pwrMode = 1'b0;
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    repeat (3) @(negedge mclk);
    cmp_val("contActive", 0, contActive);
    cmp_val("nvBusy", 0, nvBusy);
    end_of_test();
  end
endmodule : test_serial_cmd_handler
